// ### verilog/uabsp_serial_port.sv
// serial port top: registers, receiver, transmitter, pin sharing
`timescale 1ns/1ns
`default_nettype none
module uabsp_serial_port
  import uabsp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata_ff,
  output logic            rx_irq_ff,
  output logic            tx_irq_ff,
  input  wire logic       rosc_pin,
  input  wire logic       port_c_bit_three_pin_i,
  output logic            port_c_bit_three_pin_o_ff,
  output logic            port_c_bit_three_pin_oe_n_ff,
  output logic            port_c_bit_two_pin_o_ff,
  output logic            port_c_bit_two_pin_oe_n_ff,
  input  wire logic       gpio_c3_out,
  input  wire logic       gpio_c3_oe_n,
  input  wire logic       gpio_c2_out,
  input  wire logic       gpio_c2_oe_n,
  output logic            gpio_c3_in_ff
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]   cmd_ff;
  logic [3:0]   rate_ff;
  logic [15:0]  pre_ff;
  logic         pinsel_ff;
  logic [4:0]   flag_ff;
  logic [7:0]   rxbuf_ff;
  logic         full_ff;
  logic [7:0]   txhold_ff;
  logic         rx_s1_ff;
  logic         rx_s2_ff;
  uabsp_state_t rx_st_ff;
  logic [3:0]   rx_tk_ff;
  logic [2:0]   rx_bit_ff;
  logic [7:0]   rx_sh_ff;
  logic         rx_par_ff;
  uabsp_state_t tx_st_ff;
  logic [3:0]   tx_tk_ff;
  logic [2:0]   tx_bit_ff;
  logic [7:0]   tx_sh_ff;
  logic         tx_par_ff;
  logic         tx_line_ff;
  logic         rx_done;
  logic         rx_fe;
  logic         rx_pe;
  logic         tx_done;
  logic         tx_go;
  logic         rx_line;
  logic [7:0]   nxt_rdata;

  uabsp_baud_if bif ();
  assign bif.cal_en   = cmd_ff[CMD_CAL];
  assign bif.src_rosc = cmd_ff[CMD_SRC];
  assign bif.rate_sel = rate_ff;
  assign bif.prescale = pre_ff;

  uabsp_baud u_baud (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .rosc_pin (rosc_pin),
    .bif      (bif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmd_ff    <= CMD_RESET;
      rate_ff   <= RATE_RESET;
      pre_ff    <= PRE_RESET;
      pinsel_ff <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_CMD) begin
        cmd_ff <= reg_wdata & 8'h3f;
      end else if (reg_addr == ADDR_RATE) begin
        rate_ff <= reg_wdata[3:0];
      end else if (reg_addr == ADDR_PRE_LO) begin
        pre_ff[7:0] <= reg_wdata;
      end else if (reg_addr == ADDR_PRE_HI) begin
        pre_ff[15:8] <= reg_wdata;
      end else if (reg_addr == ADDR_PINSEL) begin
        pinsel_ff <= reg_wdata[0];
      end
    end
  end

  // sticky flags, write one to clear, set wins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flag_ff <= 5'h00;
      full_ff <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == ADDR_STAT) begin
        flag_ff <= flag_ff & ~reg_wdata[4:0];
      end
      if (rx_done) begin
        flag_ff[ST_RX] <= 1'b1;
        if (rx_fe) flag_ff[ST_FE] <= 1'b1;
        if (full_ff) flag_ff[ST_OE] <= 1'b1;
        if (rx_pe) flag_ff[ST_PE] <= 1'b1;
      end
      if (tx_done) flag_ff[ST_TX] <= 1'b1;
      if (reg_rd && reg_addr == ADDR_RXDATA) full_ff <= 1'b0;
      if (rx_done) full_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rxbuf_ff <= 8'h00;
    end else if (rx_done && !full_ff) begin
      rxbuf_ff <= rx_sh_ff;
    end
  end

  always_comb begin
    nxt_rdata = 8'h00;
    if (reg_addr == ADDR_CMD) nxt_rdata = cmd_ff;
    else if (reg_addr == ADDR_STAT) nxt_rdata = {1'b0, tx_st_ff != UABSP_IDLE, full_ff, flag_ff};
    else if (reg_addr == ADDR_RATE) nxt_rdata = {4'h0, rate_ff};
    else if (reg_addr == ADDR_PRE_LO) nxt_rdata = pre_ff[7:0];
    else if (reg_addr == ADDR_PRE_HI) nxt_rdata = pre_ff[15:8];
    else if (reg_addr == ADDR_TXDATA) nxt_rdata = txhold_ff;
    else if (reg_addr == ADDR_RXDATA) nxt_rdata = rxbuf_ff;
    else if (reg_addr == ADDR_PINSEL) nxt_rdata = {7'h00, pinsel_ff};
  end

  always_ff @(posedge clk) begin
    if (sys_rst) reg_rdata_ff <= 8'h00;
    else reg_rdata_ff <= reg_rd ? nxt_rdata : 8'h00;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_irq_ff <= 1'b0;
      tx_irq_ff <= 1'b0;
    end else begin
      rx_irq_ff <= flag_ff[ST_RX] & cmd_ff[CMD_RX_IE];
      tx_irq_ff <= flag_ff[ST_TX] & cmd_ff[CMD_TX_IE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receiver
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_s1_ff <= 1'b1;
      rx_s2_ff <= 1'b1;
    end else begin
      rx_s1_ff <= port_c_bit_three_pin_i;
      rx_s2_ff <= rx_s1_ff;
    end
  end
  assign rx_line = pinsel_ff ? rx_s2_ff : 1'b1;
  assign rx_done = bif.tick && rx_st_ff == UABSP_STOP && rx_tk_ff == LAST_TICK;
  assign rx_fe   = !rx_line;
  assign rx_pe   = cmd_ff[CMD_PAR_EN] && rx_par_ff;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_st_ff  <= UABSP_IDLE;
      rx_tk_ff  <= 4'h0;
      rx_bit_ff <= 3'h0;
      rx_sh_ff  <= 8'h00;
      rx_par_ff <= 1'b0;
    end else if (bif.tick) begin
      rx_tk_ff <= rx_tk_ff + 4'h1;
      case (rx_st_ff)
        UABSP_IDLE: begin
          rx_tk_ff <= 4'h0;
          if (!rx_line) rx_st_ff <= UABSP_START;
        end
        UABSP_START: begin
          if (rx_tk_ff == MID_TICK) begin
            rx_tk_ff  <= 4'h0;
            rx_bit_ff <= 3'h0;
            rx_par_ff <= cmd_ff[CMD_PAR_OD];
            rx_st_ff  <= rx_line ? UABSP_IDLE : UABSP_DATA;
          end
        end
        UABSP_DATA: begin
          if (rx_tk_ff == LAST_TICK) begin
            rx_sh_ff  <= {rx_line, rx_sh_ff[7:1]};
            rx_par_ff <= rx_par_ff ^ rx_line;
            rx_bit_ff <= rx_bit_ff + 3'h1;
            if (rx_bit_ff == 3'h7) rx_st_ff <= cmd_ff[CMD_PAR_EN] ? UABSP_PAR : UABSP_STOP;
          end
        end
        UABSP_PAR: begin
          if (rx_tk_ff == LAST_TICK) begin
            rx_par_ff <= rx_par_ff ^ rx_line;
            rx_st_ff  <= UABSP_STOP;
          end
        end
        UABSP_STOP: begin
          if (rx_tk_ff == LAST_TICK) rx_st_ff <= UABSP_IDLE;
        end
        default: rx_st_ff <= UABSP_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmitter
  assign tx_go   = reg_wr && reg_addr == ADDR_TXDATA && tx_st_ff == UABSP_IDLE;
  assign tx_done = bif.tick && tx_st_ff == UABSP_STOP && tx_tk_ff == LAST_TICK;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_st_ff   <= UABSP_IDLE;
      tx_tk_ff   <= 4'h0;
      tx_bit_ff  <= 3'h0;
      tx_sh_ff   <= 8'h00;
      tx_par_ff  <= 1'b0;
      tx_line_ff <= 1'b1;
      txhold_ff  <= 8'h00;
    end else if (tx_go) begin
      txhold_ff <= reg_wdata;
      tx_sh_ff  <= reg_wdata;
      tx_par_ff <= cmd_ff[CMD_PAR_OD] ^ (^reg_wdata);
      tx_tk_ff  <= 4'h0;
      tx_st_ff  <= UABSP_START;
    end else if (bif.tick) begin
      tx_tk_ff <= tx_tk_ff + 4'h1;
      case (tx_st_ff)
        UABSP_IDLE: tx_line_ff <= 1'b1;
        UABSP_START: begin
          tx_line_ff <= 1'b0;
          if (tx_tk_ff == LAST_TICK) begin
            tx_bit_ff <= 3'h0;
            tx_st_ff  <= UABSP_DATA;
          end
        end
        UABSP_DATA: begin
          tx_line_ff <= tx_sh_ff[0];
          if (tx_tk_ff == LAST_TICK) begin
            tx_sh_ff  <= {1'b0, tx_sh_ff[7:1]};
            tx_bit_ff <= tx_bit_ff + 3'h1;
            if (tx_bit_ff == 3'h7) tx_st_ff <= cmd_ff[CMD_PAR_EN] ? UABSP_PAR : UABSP_STOP;
          end
        end
        UABSP_PAR: begin
          tx_line_ff <= tx_par_ff;
          if (tx_tk_ff == LAST_TICK) tx_st_ff <= UABSP_STOP;
        end
        UABSP_STOP: begin
          tx_line_ff <= 1'b1;
          if (tx_tk_ff == LAST_TICK) tx_st_ff <= UABSP_IDLE;
        end
        default: tx_st_ff <= UABSP_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin sharing with port C bits two and three
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      port_c_bit_two_pin_o_ff      <= 1'b1;
      port_c_bit_two_pin_oe_n_ff   <= 1'b1;
      port_c_bit_three_pin_o_ff    <= 1'b1;
      port_c_bit_three_pin_oe_n_ff <= 1'b1;
      gpio_c3_in_ff                <= 1'b1;
    end else begin
      port_c_bit_two_pin_o_ff      <= pinsel_ff ? tx_line_ff : gpio_c2_out;
      port_c_bit_two_pin_oe_n_ff   <= pinsel_ff ? 1'b0 : gpio_c2_oe_n;
      port_c_bit_three_pin_o_ff    <= gpio_c3_out;
      port_c_bit_three_pin_oe_n_ff <= pinsel_ff ? 1'b1 : gpio_c3_oe_n;
      gpio_c3_in_ff                <= rx_s2_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_rx_flag;
    @(posedge clk) disable iff (sys_rst) rx_done |=> flag_ff[ST_RX];
  endproperty
  a_rx_flag: assert property (p_rx_flag) else $error("receive flag missing");
  property p_tx_flag;
    @(posedge clk) disable iff (sys_rst) tx_done |=> flag_ff[ST_TX];
  endproperty
  a_tx_flag: assert property (p_tx_flag) else $error("transmit flag missing");
  property p_rx_irq;
    @(posedge clk) disable iff (sys_rst)
      (flag_ff[ST_RX] && cmd_ff[CMD_RX_IE]) ##1 (flag_ff[ST_RX] && cmd_ff[CMD_RX_IE]) |-> rx_irq_ff;
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("receive interrupt not raised");
  property p_tx_irq_off;
    @(posedge clk) disable iff (sys_rst) !$past(cmd_ff[CMD_TX_IE]) |-> !tx_irq_ff;
  endproperty
  a_tx_irq_off: assert property (p_tx_irq_off) else $error("masked transmit interrupt");
  property p_overrun;
    @(posedge clk) disable iff (sys_rst) (rx_done && full_ff) |=> flag_ff[ST_OE] && full_ff;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");
  property p_parity_off;
    @(posedge clk) disable iff (sys_rst)
      (rx_done && !cmd_ff[CMD_PAR_EN] && !flag_ff[ST_PE]) |=> !flag_ff[ST_PE];
  endproperty
  a_parity_off: assert property (p_parity_off) else $error("parity error while disabled");
  property p_tx_start;
    @(posedge clk) disable iff (sys_rst)
      tx_go |=> tx_st_ff == UABSP_START;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("transmit did not start");
  property p_tx_pin;
    @(posedge clk) disable iff (sys_rst)
      $past(pinsel_ff) && pinsel_ff |-> !port_c_bit_two_pin_oe_n_ff && port_c_bit_three_pin_oe_n_ff;
  endproperty
  a_tx_pin: assert property (p_tx_pin) else $error("pin function not applied");
  property p_rdata_idle;
    @(posedge clk) disable iff (sys_rst) !$past(reg_rd) |-> reg_rdata_ff == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
  property p_start_mid;
    @(posedge clk) disable iff (sys_rst)
      (bif.tick && rx_st_ff == UABSP_START && rx_tk_ff == MID_TICK && !rx_line)
      |=> rx_st_ff == UABSP_DATA;
  endproperty
  a_start_mid: assert property (p_start_mid) else $error("start centre not taken");
  c_rx_byte: cover property (@(posedge clk) rx_done && !rx_fe);
  c_tx_byte: cover property (@(posedge clk) tx_done);
  c_overrun: cover property (@(posedge clk) rx_done && full_ff);
  c_par_err: cover property (@(posedge clk) rx_done && rx_pe);
endmodule : uabsp_serial_port
`default_nettype wire

// ### verilog/uabsp_pkg.sv
// constants shared by the serial port files
package uabsp_pkg;
  localparam int unsigned CLK_HZ      = 50000000;
  localparam int unsigned OVERSAMPLE  = 16;
  localparam int unsigned RATE_COUNT  = 10;
  localparam int unsigned RATE_BPS [RATE_COUNT] = '{1200, 2400, 4800, 9600, 19200,
                                                   38400, 51200, 57600, 102400, 115200};
  localparam logic [3:0] ADDR_CMD    = 4'h0;
  localparam logic [3:0] ADDR_STAT   = 4'h1;
  localparam logic [3:0] ADDR_RATE   = 4'h2;
  localparam logic [3:0] ADDR_PRE_LO = 4'h3;
  localparam logic [3:0] ADDR_PRE_HI = 4'h4;
  localparam logic [3:0] ADDR_TXDATA = 4'h5;
  localparam logic [3:0] ADDR_RXDATA = 4'h6;
  localparam logic [3:0] ADDR_PINSEL = 4'h7;
  localparam int CMD_RX_IE  = 0;
  localparam int CMD_TX_IE  = 1;
  localparam int CMD_PAR_EN = 2;
  localparam int CMD_PAR_OD = 3;
  localparam int CMD_SRC    = 4;
  localparam int CMD_CAL    = 5;
  localparam int ST_RX      = 0;
  localparam int ST_TX      = 1;
  localparam int ST_FE      = 2;
  localparam int ST_OE      = 3;
  localparam int ST_PE      = 4;
  localparam int ST_FULL    = 5;
  localparam int ST_BUSY    = 6;
  localparam logic [7:0]  CMD_RESET  = 8'h20;
  localparam logic [3:0]  RATE_RESET = 4'h3;
  localparam logic [15:0] PRE_RESET  = 16'h00a3;
  localparam logic [3:0]  MID_TICK   = 4'h7;
  localparam logic [3:0]  LAST_TICK  = 4'hf;
  typedef enum logic [2:0] {
    UABSP_IDLE  = 3'b000,
    UABSP_START = 3'b001,
    UABSP_DATA  = 3'b010,
    UABSP_PAR   = 3'b011,
    UABSP_STOP  = 3'b100
  } uabsp_state_t;
endpackage : uabsp_pkg

// ### verilog/uabsp_baud_if.sv
// baud generator settings and oversample tick
`timescale 1ns/1ns
`default_nettype none
interface uabsp_baud_if;
  logic        cal_en;
  logic        src_rosc;
  logic [3:0]  rate_sel;
  logic [15:0] prescale;
  logic        tick;
  modport ctl (output cal_en, output src_rosc, output rate_sel, output prescale, input tick);
  modport gen (input cal_en, input src_rosc, input rate_sel, input prescale, output tick);
endinterface : uabsp_baud_if
`default_nettype wire

// ### verilog/uabsp_baud.sv
// baud generator: calibrated table or raw prescaler
`timescale 1ns/1ns
`default_nettype none
module uabsp_baud
  import uabsp_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  sys_rst,
  input  wire logic  rosc_pin,
  uabsp_baud_if.gen  bif
);
  function automatic logic [15:0] cal_div(input logic [3:0] sel);
    int unsigned idx;
    idx = (sel < RATE_COUNT) ? int'(sel) : RATE_COUNT - 1;
    return 16'((CLK_HZ + OVERSAMPLE * RATE_BPS[idx] / 2) / (OVERSAMPLE * RATE_BPS[idx]));
  endfunction : cal_div

  logic        rosc_s1_ff;
  logic        rosc_s2_ff;
  logic        rosc_s3_ff;
  logic [15:0] cnt_ff;
  logic        tick_ff;
  logic [15:0] div;
  logic        step;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rosc_s1_ff <= 1'b0;
      rosc_s2_ff <= 1'b0;
      rosc_s3_ff <= 1'b0;
    end else begin
      rosc_s1_ff <= rosc_pin;
      rosc_s2_ff <= rosc_s1_ff;
      rosc_s3_ff <= rosc_s2_ff;
    end
  end

  always_comb begin
    div  = bif.cal_en ? cal_div(bif.rate_sel) : bif.prescale;
    if (div < 16'h0002) div = 16'h0002;
    step = (bif.cal_en || !bif.src_rosc) ? 1'b1 : (rosc_s2_ff && !rosc_s3_ff);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_ff  <= 16'h0000;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= 1'b0;
      if (step) begin
        if (cnt_ff >= div - 16'h0001) begin
          cnt_ff  <= 16'h0000;
          tick_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff + 16'h0001;
        end
      end
    end
  end
  assign bif.tick = tick_ff;

  property p_tick_single;
    @(posedge clk) disable iff (sys_rst) tick_ff |=> !tick_ff;
  endproperty
  a_tick_single: assert property (p_tick_single) else $error("tick lasted two cycles");
  property p_fast_rate;
    @(posedge clk) disable iff (sys_rst)
      (bif.cal_en && bif.rate_sel == 4'h9 && $stable(bif.rate_sel)) && tick_ff
      |-> ##[1:27] tick_ff;
  endproperty
  a_fast_rate: assert property (p_fast_rate) else $error("top rate tick too slow");
  c_raw_tick: cover property (@(posedge clk) !bif.cal_en && tick_ff);
endmodule : uabsp_baud
`default_nettype wire

// ### test/uabsp_remote.sv
// remote serial transceiver model facing the serial port
`timescale 1ns/1ns
`default_nettype none
module uabsp_remote (
  input  wire logic        tx_line,
  output logic             rx_line,
  input  wire logic        par_en,
  input  wire logic        par_odd,
  input  wire logic [31:0] bit_ns,
  output logic      [7:0]  got_byte,
  output logic             got_par_ok,
  output logic             got_stop_ok,
  output logic      [7:0]  got_count
);
  logic [7:0] shf;
  //////////////////////////////////////////////////////////////////////////////
  // receive frames sent by the port
  initial begin
    got_count   = 8'h00;
    got_byte    = 8'h00;
    got_par_ok  = 1'b0;
    got_stop_ok = 1'b0;
    forever begin
      @(negedge tx_line);
      #(bit_ns / 2);
      if (tx_line === 1'b0) begin
        for (int i = 0; i < 8; i++) begin
          #(bit_ns);
          shf[i] = tx_line;
        end
        got_par_ok = 1'b1;
        if (par_en) begin
          #(bit_ns);
          got_par_ok = (tx_line === (^shf ^ par_odd));
        end
        #(bit_ns);
        got_stop_ok = (tx_line === 1'b1);
        got_byte    = shf;
        got_count   = got_count + 8'h01;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // send one frame, optionally with bad parity or a short low stop
  initial rx_line = 1'b1;
  task automatic send(input logic [7:0] d, input logic bad_par, input logic bad_stop);
    rx_line = 1'b0;
    #(bit_ns);
    for (int i = 0; i < 8; i++) begin
      rx_line = d[i];
      #(bit_ns);
    end
    if (par_en) begin
      rx_line = ^d ^ par_odd ^ bad_par;
      #(bit_ns);
    end
    rx_line = ~bad_stop;
    #(bit_ns * 10 / 16);
    rx_line = 1'b1;
    #(bit_ns * 6 / 16 + bit_ns);
  endtask : send
endmodule : uabsp_remote
`default_nettype wire

// ### test/test_uart_autobaud_serial_port.sv
// self-checking bench for the autobaud serial port
`timescale 1ns/1ns
`default_nettype none
module test_uart_autobaud_serial_port
  import uabsp_pkg::*;
;
  logic        clk;
  logic        sys_rst;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata_ff;
  logic        rx_irq_ff;
  logic        tx_irq_ff;
  logic [1:0]  rosc_div;
  logic        c3_o;
  logic        c3_oe_n;
  logic        c2_o;
  logic        c2_oe_n;
  logic        c3_in;
  logic        gpio_c3_out;
  logic        gpio_c3_oe_n;
  logic        gpio_c2_out;
  logic        gpio_c2_oe_n;
  logic        tx_line;
  logic        rx_line;
  logic        pin3_level;
  logic        par_en;
  logic        par_odd;
  logic [31:0] bit_ns;
  logic [7:0]  got_byte;
  logic [7:0]  got_count;
  logic        got_par_ok;
  logic        got_stop_ok;
  int          failures;
  int          comparisons;
  //////////////////////////////////////////////////////////////////////////////
  // clock, oscillator, pin wires
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial rosc_div = 2'h0;
  always @(posedge clk) rosc_div <= rosc_div + 2'h1;
  // released C2 line is pulled high; released C3 line carries the partner's rx_line
  assign tx_line    = (c2_oe_n === 1'b0) ? c2_o : 1'b1;
  assign pin3_level = (c3_oe_n === 1'b0) ? c3_o : rx_line;
  uabsp_serial_port dut (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .rx_irq_ff(rx_irq_ff), .tx_irq_ff(tx_irq_ff), .rosc_pin(rosc_div[1]),
    .port_c_bit_three_pin_i(pin3_level), .port_c_bit_three_pin_o_ff(c3_o),
    .port_c_bit_three_pin_oe_n_ff(c3_oe_n), .port_c_bit_two_pin_o_ff(c2_o),
    .port_c_bit_two_pin_oe_n_ff(c2_oe_n), .gpio_c3_out(gpio_c3_out),
    .gpio_c3_oe_n(gpio_c3_oe_n), .gpio_c2_out(gpio_c2_out),
    .gpio_c2_oe_n(gpio_c2_oe_n), .gpio_c3_in_ff(c3_in)
  );
  uabsp_remote partner (
    .tx_line(tx_line), .rx_line(rx_line), .par_en(par_en), .par_odd(par_odd),
    .bit_ns(bit_ns), .got_byte(got_byte), .got_par_ok(got_par_ok),
    .got_stop_ok(got_stop_ok), .got_count(got_count)
  );
  //////////////////////////////////////////////////////////////////////////////
  // bus tasks and checks
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    chk($sformatf("reg %0h", a), reg_rdata_ff, exp);
  endtask : rd
  task automatic wait_irq(input logic is_tx);
    int n;
    n = 0;
    while (((is_tx ? tx_irq_ff : rx_irq_ff) !== 1'b1) && n < 20000) begin
      @(posedge clk);
      n++;
    end
    #1;
    chk("irq", {7'h00, is_tx ? tx_irq_ff : rx_irq_ff}, 8'h01);
  endtask : wait_irq
  task automatic tx_case(input logic [7:0] d);
    wr(ADDR_TXDATA, d);
    rd(ADDR_STAT, 8'h40);
    wr(ADDR_TXDATA, ~d);
    wait_irq(1'b1);
    chk("tx byte", got_byte, d);
    chk("tx parity", {7'h00, got_par_ok}, 8'h01);
    chk("tx stop", {7'h00, got_stop_ok}, 8'h01);
    rd(ADDR_STAT, 8'h02);
    rd(ADDR_TXDATA, d);
    wr(ADDR_STAT, 8'h1f);
  endtask : tx_case
  task automatic rx_case(input logic [7:0] d, input logic bp, input logic bs,
                         input logic [7:0] st);
    partner.send(d, bp, bs);
    wait_irq(1'b0);
    rd(ADDR_STAT, st);
    rd(ADDR_RXDATA, d);
    rd(ADDR_STAT, st & 8'hdf);
    wr(ADDR_STAT, 8'h1f);
  endtask : rx_case
  task automatic give_verdict();
    if (failures == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  //////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    #1000000;
    failures++;
    give_verdict();
  end
  //////////////////////////////////////////////////////////////////////////////
  // test sequence
  initial begin
    sys_rst = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    gpio_c3_out = 1'b1;
    gpio_c3_oe_n = 1'b1;
    gpio_c2_out = 1'b1;
    gpio_c2_oe_n = 1'b1;
    par_en = 1'b0;
    par_odd = 1'b0;
    bit_ns = 32'd8640;
    failures = 0;
    comparisons = 0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(ADDR_CMD, CMD_RESET);
    rd(ADDR_STAT, 8'h00);
    rd(ADDR_RATE, {4'h0, RATE_RESET});
    rd(ADDR_PRE_LO, PRE_RESET[7:0]);
    rd(ADDR_PRE_HI, PRE_RESET[15:8]);
    rd(ADDR_PINSEL, 8'h00);
    rd(4'h8, 8'h00);
    rd(4'hf, 8'h00);
    @(posedge clk);
    gpio_c3_out  <= 1'b0;
    gpio_c3_oe_n <= 1'b0;
    gpio_c2_oe_n <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk("c3 drive", {6'h00, c3_o, c3_oe_n}, 8'h00);
    chk("c2 drive", {6'h00, c2_o, c2_oe_n}, 8'h02);
    chk("c3 input", {7'h00, c3_in}, 8'h00);
    wr(ADDR_PINSEL, 8'h01);
    repeat (6) @(posedge clk);
    #1;
    chk("uart pins", {4'h0, c3_oe_n, c2_oe_n, c2_o, c3_in}, 8'h0b);
    wr(ADDR_RATE, 8'h09);
    wr(ADDR_CMD, 8'h23);
    tx_case(8'h5a);
    rx_case(8'ha5, 1'b0, 1'b0, 8'h21);
    wr(ADDR_PRE_LO, 8'h02);
    bit_ns = 32'd640;
    for (int k = 0; k < 2; k++) begin
      par_en  = 1'b1;
      par_odd = k[0];
      wr(ADDR_CMD, {4'h0, k[0], 3'h7});
      tx_case(8'h3c);
      rx_case(8'hc3, 1'b0, 1'b0, 8'h21);
      rx_case(8'h96, 1'b1, 1'b0, 8'h31);
    end
    par_en = 1'b0;
    wr(ADDR_CMD, 8'h03);
    rx_case(8'h5f, 1'b0, 1'b1, 8'h25);
    partner.send(8'h11, 1'b0, 1'b0);
    partner.send(8'h22, 1'b0, 1'b0);
    rd(ADDR_STAT, 8'h29);
    rd(ADDR_RXDATA, 8'h11);
    wr(ADDR_STAT, 8'h1f);
    wr(ADDR_CMD, 8'h12);
    bit_ns = 32'd2560;
    tx_case(8'h81);
    partner.send(8'h7e, 1'b0, 1'b0);
    rd(ADDR_STAT, 8'h21);
    chk("rx masked", {7'h00, rx_irq_ff}, 8'h00);
    rd(ADDR_RXDATA, 8'h7e);
    give_verdict();
  end
endmodule : test_uart_autobaud_serial_port
`default_nettype wire
